/* sqc_ctrl.sv */
// Global QoS, snooping and mirroring control registers with their classification decisions.
// Assumes one core clock, synchronous inputs and a never-waiting register port master.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "sqc_defines.svh"

// Behaviour
// - Register 0x035E gives the priority for DSCP 0x3C in bits 2:0 and DSCP 0x3D in bits 6:4, both reset to zero.
// - Register 0x035F gives the priority for DSCP 0x3E in bits 2:0 and DSCP 0x3F in bits 6:4, bits 7 and 3 read zero.
// - With bit 6 of 0x0370 set every IGMP packet goes to the host port, otherwise none is snooped, reset clear.
// - With bit 2 set every MLD packet goes to the host port, otherwise MLD snooping is off.
// - With bit 3 set a packet is MLD when next header, or hop-by-hop next header after 0, is 43, 44, 50, 51 or 60.
// - With bit 3 clear a packet is MLD when next header, or hop-by-hop next header after 0, is 1 or 58.
// - With bit 0 set a frame is mirrored only when both source and destination ports match the sniffed ports.
// - With bit 0 clear a frame is mirrored when either source or destination port matches.
// - Nothing is mirrored unless the per-port ingress mirroring settings are also enabled.
// - Register 0x0378 holds the red DSCP in bits 5:4 reset 11b, and bits 7:6 read zero.
// - The same register holds yellow in bits 3:2 reset 10b and green in bits 1:0 reset 01b.
// - Bit 7 of 0x037C forces PTP event messages to the programmed priority, clear lets QoS decide.
// - Bits 3:0 of 0x037C, reset 1111b, are the forced PTP event priority and bits 6:4 read zero.
module sqc_ctrl (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [15:0]       addr_i,
	input  wire sqc_pkg::sqc_byte_t wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic [7:0]             rdata_o,
	input  wire logic              pkt_valid_i,
	input  wire logic [5:0]        pkt_dscp_i,
	input  wire logic              pkt_is_igmp_i,
	input  wire logic              pkt_is_ipv6_i,
	input  wire logic [7:0]        pkt_next_hdr_i,
	input  wire logic [7:0]        pkt_hbh_next_hdr_i,
	input  wire logic              pkt_is_ptp_event_i,
	input  wire logic [3:0]        pkt_qos_prio_i,
	input  wire logic              src_port_match_i,
	input  wire logic              dst_port_match_i,
	input  wire logic              port_mirror_en_i,
	output logic                   dscp_hit_o,
	output logic [2:0]             dscp_prio_o,
	output logic                   to_host_o,
	output logic                   mirror_o,
	output logic [3:0]             queue_prio_o,
	output logic [1:0]             wred_red_dscp_o,
	output logic [1:0]             wred_yellow_dscp_o,
	output logic [1:0]             wred_green_dscp_o
);
	import sqc_pkg::*;

	// ==========================================
	// Register storage
	sqc_byte_t map30_q;
	sqc_byte_t map31_q;
	sqc_byte_t snoop_q;
	sqc_byte_t wred_q;
	sqc_byte_t ptp_q;

	// Only writable bits are stored; reserved bits stay zero
	function automatic sqc_byte_t merge(input sqc_byte_t d, input sqc_byte_t mask);
		return d & mask;
	endfunction

	// One next-header code against the criteria picked by the option bit
	function automatic logic mld_code(input logic [7:0] nh, input logic opt);
		logic hit;
		if (opt) begin
			hit = (nh == `SQC_NH_ROUTING) ||
			      (nh == `SQC_NH_FRAGMENT) ||
			      (nh == `SQC_NH_ESP) ||
			      (nh == `SQC_NH_AH) ||
			      (nh == `SQC_NH_DEST_OPTS);
		end else begin
			hit = (nh == `SQC_NH_ICMPV4) ||
			      (nh == `SQC_NH_ICMPV6);
		end
		return hit;
	endfunction

	// Upper or lower priority field of a mapping byte
	function automatic sqc_prio3_t map_field(input sqc_byte_t map, input logic upper);
		sqc_prio3_t f;
		if (upper) begin
			f = map[6:4];
		end else begin
			f = map[2:0];
		end
		return f;
	endfunction

	// Full 16-bit compare, so no alias of a register ever answers
	function automatic logic addr_is(input logic [15:0] a, input logic [15:0] target);
		return a == target;
	endfunction

	// ==========================================
	// Address decode, shared by the write and read paths
	logic sel_map30;
	logic sel_map31;
	logic sel_snoop;
	logic sel_wred;
	logic sel_ptp;
	always_comb begin
		sel_map30 = addr_is(addr_i, `SQC_ADDR_DSCP_MAP_30);
		sel_map31 = addr_is(addr_i, `SQC_ADDR_DSCP_MAP_31);
		sel_snoop = addr_is(addr_i, `SQC_ADDR_MIRROR_SNOOP);
		sel_wred  = addr_is(addr_i, `SQC_ADDR_WRED_MAP);
		sel_ptp   = addr_is(addr_i, `SQC_ADDR_PTP_EVENT);
	end

	// Strobe and decode meet once here; each register process sees only its own enable
	logic wr_map30;
	logic wr_map31;
	logic wr_snoop;
	logic wr_wred;
	logic wr_ptp;
	always_comb begin
		wr_map30 = wr_i && sel_map30;
		wr_map31 = wr_i && sel_map31;
		wr_snoop = wr_i && sel_snoop;
		wr_wred  = wr_i && sel_wred;
		wr_ptp   = wr_i && sel_ptp;
	end

	// ==========================================
	// Register writes: a write lands at the edge that samples the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			map30_q <= `SQC_RST_DSCP_MAP;
		end else if (wr_map30) begin
			map30_q <= merge(wdata_i, `SQC_MASK_DSCP_MAP);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			map31_q <= `SQC_RST_DSCP_MAP;
		end else if (wr_map31) begin
			map31_q <= merge(wdata_i, `SQC_MASK_DSCP_MAP);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			snoop_q <= `SQC_RST_MIRROR_SNOOP;
		end else if (wr_snoop) begin
			snoop_q <= merge(wdata_i, `SQC_MASK_MIRROR_SNOOP);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wred_q <= `SQC_RST_WRED_MAP;
		end else if (wr_wred) begin
			wred_q <= merge(wdata_i, `SQC_MASK_WRED_MAP);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptp_q <= `SQC_RST_PTP_EVENT;
		end else if (wr_ptp) begin
			ptp_q <= merge(wdata_i, `SQC_MASK_PTP_EVENT);
		end
	end

	// ==========================================
	// Read port: data stand one cycle after the strobe, zero otherwise
	sqc_byte_t reg_view;
	sqc_byte_t rdata_d;
	always_comb begin
		if (sel_map30) begin
			reg_view = map30_q;
		end else if (sel_map31) begin
			reg_view = map31_q;
		end else if (sel_snoop) begin
			reg_view = snoop_q;
		end else if (sel_wred) begin
			reg_view = wred_q;
		end else if (sel_ptp) begin
			reg_view = ptp_q;
		end else begin
			// Unmapped addresses read zero
			reg_view = 8'h00;
		end
	end

	// Zero outside a read, so a stale value is never mistaken for data
	always_comb begin
		rdata_d = rd_i ? reg_view : 8'h00;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rdata_d;
		end
	end

	// ==========================================
	// DSCP to priority for the top four code points
	// Lower code points are mapped elsewhere and pass here as a miss
	logic       hit_d;
	sqc_prio3_t prio_d;
	always_comb begin
		hit_d  = pkt_valid_i;
		prio_d = 3'h0;
		case (pkt_dscp_i)
			`SQC_DSCP_3C: prio_d = map_field(map30_q, 1'b0);
			`SQC_DSCP_3D: prio_d = map_field(map30_q, 1'b1);
			`SQC_DSCP_3E: prio_d = map_field(map31_q, 1'b0);
			`SQC_DSCP_3F: prio_d = map_field(map31_q, 1'b1);
			default:      hit_d  = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dscp_hit_o  <= 1'b0;
			dscp_prio_o <= 3'h0;
		end else begin
			dscp_hit_o  <= hit_d;
			dscp_prio_o <= prio_d;
		end
	end

	// ==========================================
	// Snooping toward the host port
	logic nh_hit;
	logic hbh_hit;
	logic is_mld;
	logic igmp_fwd;
	logic mld_fwd;
	always_comb begin
		// One option bit picks the code set for both header positions
		nh_hit   = mld_code(pkt_next_hdr_i, snoop_q[`SQC_BIT_MLD_OPT]);
		hbh_hit  = (pkt_next_hdr_i == `SQC_NH_HOP_BY_HOP) &&
		           mld_code(pkt_hbh_next_hdr_i, snoop_q[`SQC_BIT_MLD_OPT]);
		is_mld   = pkt_is_ipv6_i && (nh_hit || hbh_hit);
		igmp_fwd = snoop_q[`SQC_BIT_IGMP_EN] && pkt_is_igmp_i;
		// Option is only consulted behind the enable
		mld_fwd  = snoop_q[`SQC_BIT_MLD_EN] && is_mld;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			to_host_o <= 1'b0;
		end else begin
			to_host_o <= pkt_valid_i && (igmp_fwd || mld_fwd);
		end
	end

	// ==========================================
	// Mirroring filter
	logic sniff_hit;
	logic mirror_d;
	always_comb begin
		if (snoop_q[`SQC_BIT_SNIFF_AND]) begin
			sniff_hit = src_port_match_i && dst_port_match_i;
		end else begin
			sniff_hit = src_port_match_i || dst_port_match_i;
		end
	end

	// The global filter alone never mirrors; the port must ask for it as well
	always_comb begin
		mirror_d = pkt_valid_i && port_mirror_en_i && sniff_hit;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mirror_o <= 1'b0;
		end else begin
			mirror_o <= mirror_d;
		end
	end

	// ==========================================
	// PTP event priority override at queuing
	logic ptp_force;
	// Non-event messages are not seen here and keep their normal priority
	always_comb begin
		ptp_force = pkt_is_ptp_event_i && ptp_q[`SQC_BIT_PTP_OVR];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			queue_prio_o <= 4'h0;
		end else if (ptp_force) begin
			queue_prio_o <= ptp_q[3:0];
		end else begin
			queue_prio_o <= pkt_qos_prio_i;
		end
	end

	// ==========================================
	// WRED colour code points
	// Outputs leave reset already showing the register's reset fields
	localparam sqc_byte_t wred_rst = `SQC_RST_WRED_MAP;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wred_red_dscp_o    <= wred_rst[5:4];
			wred_yellow_dscp_o <= wred_rst[3:2];
			wred_green_dscp_o  <= wred_rst[1:0];
		end else begin
			wred_red_dscp_o    <= wred_q[5:4];
			wred_yellow_dscp_o <= wred_q[3:2];
			wred_green_dscp_o  <= wred_q[1:0];
		end
	end
endmodule

/* sqc_ctrl_properties.sv */
// Port-level assertions for the QoS, snoop and mirror control bank.
// Bound to sqc_ctrl from the bench top file; sees only that module's ports.
`timescale 1ns/10ps
`include "sqc_defines.svh"
module sqc_ctrl_properties (
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic [15:0]        addr_i,
	input wire sqc_pkg::sqc_byte_t wdata_i,
	input wire logic               wr_i,
	input wire logic               rd_i,
	input wire logic [7:0]         rdata_o,
	input wire logic               pkt_valid_i,
	input wire logic               pkt_is_igmp_i,
	input wire logic               pkt_is_ptp_event_i,
	input wire logic [3:0]         pkt_qos_prio_i,
	input wire logic               src_port_match_i,
	input wire logic               dst_port_match_i,
	input wire logic               port_mirror_en_i,
	input wire logic               to_host_o,
	input wire logic               mirror_o,
	input wire logic [3:0]         queue_prio_o
);
	import sqc_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// Shadow copies, so decisions can be tied to what software wrote
	logic [7:0] ctl_q;
	logic [7:0] ptp_q;
	logic [3:0] ptp_prio;
	assign ptp_prio = ptp_q[3:0];
	logic both_match;
	logic any_match;
	assign both_match = src_port_match_i && dst_port_match_i;
	assign any_match  = src_port_match_i || dst_port_match_i;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctl_q <= `SQC_RST_MIRROR_SNOOP;
		else if (wr_i && addr_i == `SQC_ADDR_MIRROR_SNOOP)
			ctl_q <= wdata_i & `SQC_MASK_MIRROR_SNOOP;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ptp_q <= `SQC_RST_PTP_EVENT;
		else if (wr_i && addr_i == `SQC_ADDR_PTP_EVENT)
			ptp_q <= wdata_i & `SQC_MASK_PTP_EVENT;
	end
	sequence ctl_read_s;
		rd_i && addr_i == `SQC_ADDR_MIRROR_SNOOP;
	endsequence
	sequence mirror_req_s;
		pkt_valid_i && port_mirror_en_i;
	endsequence
	// ==========================================
	// Assertions
	ctl_readback_a: assert property (ctl_read_s |=> rdata_o == ctl_q)
		else $error("Control register read back wrong");
	read_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("Read data not zero outside a read");
	igmp_fwd_a: assert property (pkt_valid_i && pkt_is_igmp_i && ctl_q[`SQC_BIT_IGMP_EN] |=> to_host_o)
		else $error("IGMP packet not sent to host");
	mirror_gate_a: assert property (!(pkt_valid_i && port_mirror_en_i) |=> !mirror_o)
		else $error("Mirror without per-port enable");
	mirror_and_a: assert property (mirror_req_s ##0 ctl_q[0] |=> mirror_o == $past(both_match))
		else $error("Mirror AND filter wrong");
	mirror_or_a: assert property (mirror_req_s ##0 !ctl_q[0] |=> mirror_o == $past(any_match))
		else $error("Mirror OR filter wrong");
	ptp_force_a: assert property (pkt_is_ptp_event_i && ptp_q[7] |=> queue_prio_o == $past(ptp_prio))
		else $error("Forced event priority wrong");
	qos_pass_a: assert property (!(pkt_is_ptp_event_i && ptp_q[7]) |=> queue_prio_o == $past(pkt_qos_prio_i))
		else $error("Normal priority not passed");
endmodule

/* sqc_ctrl_tb.sv */
// Self-checking bench for the control bank: register port and per-packet decisions.
// Drives every port itself; expectations come from a shadow copy of the registers.
`timescale 1ns/10ps
`include "sqc_defines.svh"
module sqc_ctrl_tb;
	import sqc_pkg::*;
	// ==========================================
	// Signals and shadow state
	logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, pkt_valid_i = 0, pkt_is_igmp_i = 0, pkt_is_ipv6_i = 0;
	logic pkt_is_ptp_event_i = 0, src_port_match_i = 0, dst_port_match_i = 0, port_mirror_en_i = 0;
	logic dscp_hit_o, to_host_o, mirror_o, rd_d = 0, pk_d = 0, pk_on = 0;
	logic [15:0] addr_i = 16'h0000;
	sqc_byte_t wdata_i = 8'h00, rdata_o;
	logic [7:0] pkt_next_hdr_i = 8'h00, pkt_hbh_next_hdr_i = 8'h00;
	logic [5:0] pkt_dscp_i = 6'h00;
	logic [3:0] pkt_qos_prio_i = 4'h0, queue_prio_o;
	logic [2:0] dscp_prio_o;
	logic [1:0] wred_red_dscp_o, wred_yellow_dscp_o, wred_green_dscp_o;
	// Last entry is an unmapped address: writes vanish, reads give zero
	logic [15:0] adr [6] = '{16'h035E, 16'h035F, 16'h0370, 16'h0378, 16'h037C, 16'h0371};
	sqc_byte_t msk [6] = '{8'h77, 8'h77, 8'h4D, 8'h3F, 8'h8F, 8'h00};
	sqc_byte_t mdl [6] = '{8'h00, 8'h00, 8'h00, 8'h39, 8'h0F, 8'h00};
	logic [7:0] nhc [10] = '{8'h00, 8'h01, 8'h3A, 8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C, 8'h06, 8'h11};
	sqc_byte_t rq [$];
	logic [15:0] pq [$];
	logic [15:0] pk_got;
	int mismatches = 0, n_compared = 0, cycles = 0;
	sqc_ctrl uut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pkt_valid_i, .pkt_dscp_i, .pkt_is_igmp_i,
		.pkt_is_ipv6_i, .pkt_next_hdr_i, .pkt_hbh_next_hdr_i, .pkt_is_ptp_event_i, .pkt_qos_prio_i, .src_port_match_i,
		.dst_port_match_i, .port_mirror_en_i, .dscp_hit_o, .dscp_prio_o, .to_host_o, .mirror_o, .queue_prio_o,
		.wred_red_dscp_o, .wred_yellow_dscp_o, .wred_green_dscp_o);
	always #12.5 clk_i = ~clk_i;
	// ==========================================
	// Tasks
	function automatic logic mset(logic [7:0] x, logic opt);
		return opt ? (x inside {8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C}) : (x inside {8'h01, 8'h3A});
	endfunction
	task automatic cmp_rd(sqc_byte_t got, sqc_byte_t exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: read got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_pkt(logic [15:0] got, logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: packet got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(logic w, logic [2:0] i, sqc_byte_t d);
		@(posedge clk_i);
		{pk_on, pkt_valid_i, wr_i, rd_i} <= {2'b00, w, !w};
		addr_i <= adr[i];
		wdata_i <= d;
		if (w)
			mdl[i] = d & msk[i];
		else
			rq.push_back(mdl[i]);
	endtask
	task automatic pkt();
		logic [31:0] r;
		logic [7:0] m;
		logic hit;
		r = $urandom;
		@(posedge clk_i);
		{wr_i, rd_i, pk_on} <= 3'b001;
		{pkt_valid_i, pkt_is_igmp_i, pkt_is_ipv6_i, pkt_is_ptp_event_i, src_port_match_i, dst_port_match_i,
			port_mirror_en_i, pkt_qos_prio_i} <= r[10:0];
		pkt_dscp_i <= r[11] ? r[17:12] : {4'hF, r[13:12]};
		pkt_next_hdr_i <= nhc[r[21:18] % 10];
		pkt_hbh_next_hdr_i <= nhc[r[25:22] % 10];
		m = {2'b00, r[11] ? r[17:12] : {4'hF, r[13:12]}};
		// The mapped field shows for any top code point; only the hit flag needs a valid packet
		hit = m[5:2] == 4'hF;
		m = m[1] ? mdl[1] : mdl[0];
		pq.push_back({r[10] && hit, hit ? (r[12] ? m[6:4] : m[2:0]) : 3'b000,
			r[10] && ((r[9] && mdl[2][6]) || (r[8] && mdl[2][2] && (mset(nhc[r[21:18] % 10], mdl[2][3])
			|| (nhc[r[21:18] % 10] == 8'h00 && mset(nhc[r[25:22] % 10], mdl[2][3]))))),
			r[10] && r[4] && (mdl[2][0] ? (r[6] && r[5]) : (r[6] || r[5])),
			(r[7] && mdl[4][7]) ? mdl[4][3:0] : r[3:0], mdl[3][5:0]});
	endtask
	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========================================
	// Result watcher and hang guard
	always @(posedge clk_i) begin
		rd_d <= rd_i;
		pk_d <= pk_on;
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			mismatches++;
			summarize();
		end
	end
	assign pk_got = {dscp_hit_o, dscp_prio_o, to_host_o, mirror_o, queue_prio_o, wred_red_dscp_o, wred_yellow_dscp_o,
		wred_green_dscp_o};
	always @(negedge clk_i) begin
		if (rd_d)
			cmp_rd(rdata_o, rq.pop_front());
		if (pk_d)
			cmp_pkt(pk_got, pq.pop_front());
	end
	// ==========================================
	// Main sequence: reset values, reserved bits, then mixed random traffic
	initial begin
		void'($urandom(32'h7044BA42));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) bus(1'b0, 3'(i), 8'h00);
		for (int i = 0; i < 6; i++) bus(1'b1, 3'(i), 8'hFF);
		for (int i = 0; i < 6; i++) bus(1'b0, 3'(i), 8'h00);
		for (int i = 0; i < 3000; i++) begin
			case ($urandom % 10)
				0: bus(1'b1, 3'($urandom % 6), 8'($urandom));
				1: bus(1'b0, 3'($urandom % 6), 8'h00);
				default: pkt();
			endcase
		end
		@(posedge clk_i);
		{wr_i, rd_i, pk_on} <= 3'b000;
		repeat (3) @(posedge clk_i);
		summarize();
	end
endmodule
bind sqc_ctrl sqc_ctrl_properties chk (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pkt_valid_i,
	.pkt_is_igmp_i, .pkt_is_ptp_event_i, .pkt_qos_prio_i, .src_port_match_i, .dst_port_match_i, .port_mirror_en_i,
	.to_host_o, .mirror_o, .queue_prio_o);

/* sqc_defines.svh */
// Register offsets, field positions, reset values for the switch QoS/snoop/mirror control bank.
// Assumes byte-wide registers on a plain 16-bit address port.
`ifndef SQC_DEFINES_SVH
`define SQC_DEFINES_SVH

// ==========================================
// Offsets
`define SQC_ADDR_DSCP_MAP_30   16'h035E
`define SQC_ADDR_DSCP_MAP_31   16'h035F
`define SQC_ADDR_MIRROR_SNOOP  16'h0370
`define SQC_ADDR_WRED_MAP      16'h0378
`define SQC_ADDR_PTP_EVENT     16'h037C

// ==========================================
// Field positions
`define SQC_BIT_IGMP_EN        6
`define SQC_BIT_MLD_OPT        3
`define SQC_BIT_MLD_EN         2
`define SQC_BIT_SNIFF_AND      0
`define SQC_BIT_PTP_OVR        7

// ==========================================
// Reset values and writable masks
`define SQC_RST_DSCP_MAP       8'h00
`define SQC_RST_MIRROR_SNOOP   8'h00
`define SQC_RST_WRED_MAP       8'h39
`define SQC_RST_PTP_EVENT      8'h0F
`define SQC_MASK_DSCP_MAP      8'h77
`define SQC_MASK_MIRROR_SNOOP  8'h4D
`define SQC_MASK_WRED_MAP      8'h3F
`define SQC_MASK_PTP_EVENT     8'h8F

// ==========================================
// IPv6 next-header codes
`define SQC_NH_HOP_BY_HOP      8'h00
`define SQC_NH_ICMPV4          8'h01
`define SQC_NH_ICMPV6          8'h3A
`define SQC_NH_ROUTING         8'h2B
`define SQC_NH_FRAGMENT        8'h2C
`define SQC_NH_ESP             8'h32
`define SQC_NH_AH              8'h33
`define SQC_NH_DEST_OPTS       8'h3C

// ==========================================
// DSCP code points served here
`define SQC_DSCP_3C            6'h3C
`define SQC_DSCP_3D            6'h3D
`define SQC_DSCP_3E            6'h3E
`define SQC_DSCP_3F            6'h3F

`endif

/* sqc_pkg.sv */
// Types shared by the switch QoS/snoop/mirror control bank.
// Assumes nothing beyond a SystemVerilog compiler.
package sqc_pkg;
	typedef logic [7:0] sqc_byte_t;
	typedef logic [2:0] sqc_prio3_t;
	typedef logic [3:0] sqc_prio4_t;
	typedef logic [1:0] sqc_dscp2_t;
endpackage
